// ### hdl/serial_in_parallel_out_latch.sv
// serial-in parallel-out shift register with storage register and three-state outputs
`timescale 1ns/100ps
// Function
// - eight-stage shift register feeds an eight-bit storage register.
// - parallel outputs float while output_enable_n high, drive stored value when low.
// - shift_clear_n low clears every shift stage, overriding clock and serial input.
// - shift_clock rising edge moves serial_in into stage 0, others take predecessor.
// - storage_clock rising edge copies all shift stages into storage register.
// - independent clocks; tied clocks make storage lag shift by one pulse.
// - last shift stage is always driven on cascade_serial_out.
module serial_in_parallel_out_latch
  import sipo_pkg::*;
(
  // system
  input  wire logic               clk,
  input  wire logic               srst,
  // link side, shift clock domain
  input  wire logic               shift_clock,
  input  wire logic               serial_in,
  input  wire logic               shift_clear_n,
  // storage controls, clk domain pins
  input  wire logic               storage_clock,
  input  wire logic               output_enable_n,
  // parallel outputs, output enable low while driving
  output logic [STAGE_W-1:0]      parallel_out,
  output logic [STAGE_W-1:0]      parallel_oe_n,
  // cascade
  output logic                    cascade_serial_out
);

  // shift domain state, clocked by shift_clock
  typedef struct packed {
    logic [STAGE_W-1:0] stages;
  } shift_st_t;

  // clk domain state
  typedef struct packed {
    logic [SYNC_DEPTH-1:0] clr_sync;
    logic [SYNC_DEPTH-1:0] sclk_sync;
    logic [SYNC_DEPTH-1:0] oe_sync;
    logic [SYNC_DEPTH-1:0][STAGE_W-1:0] stg_sync;
    logic                  sclk_last;
    logic [STAGE_W-1:0]    snap;
    logic [1:0]            buf_cnt;
    logic [STAGE_W-1:0]    buf0;
    logic [STAGE_W-1:0]    buf1;
    logic [STAGE_W-1:0]    store;
    logic                  oe_n;
  } main_st_t;

  shift_st_t sh_q;
  shift_st_t sh_d;
  main_st_t  m_q;
  main_st_t  m_d;
  logic      in_valid;
  logic      in_ready;
  logic      out_valid;
  logic      out_ready;
  logic      clr_now;
  logic      sclk_rise;

  // shift register; clear is held async as on the pin
  always_comb begin
    sh_d = sh_q;
    sh_d.stages = {sh_q.stages[STAGE_W-2:0], serial_in};
  end

  always_ff @(posedge shift_clock or negedge shift_clear_n) begin
    if (!shift_clear_n) begin
      sh_q.stages <= SHIFT_RST;
    end else begin
      sh_q <= sh_d;
    end
  end

  // clk domain: synchronisers, snapshot buffer, storage register
  always_comb begin
    m_d           = m_q;
    m_d.clr_sync  = {m_q.clr_sync[SYNC_DEPTH-2:0], ~shift_clear_n};
    m_d.sclk_sync = {m_q.sclk_sync[SYNC_DEPTH-2:0], storage_clock};
    m_d.oe_sync   = {m_q.oe_sync[SYNC_DEPTH-2:0], output_enable_n};
    m_d.stg_sync  = {m_q.stg_sync[SYNC_DEPTH-2:0], sh_q.stages};
    if (m_q.oe_sync[2] == m_q.oe_sync[1]) begin
      m_d.oe_n = m_q.oe_sync[2];
    end
    if (m_q.sclk_sync[2] == m_q.sclk_sync[1]) begin
      m_d.sclk_last = m_q.sclk_sync[2];
    end
    // snapshot follows settled stages; same depth as storage edge keeps the lag
    if (m_q.stg_sync[2] == m_q.stg_sync[1]) begin
      m_d.snap = m_q.stg_sync[2];
    end
    if (clr_now) begin
      m_d.snap = SHIFT_RST;
    end
    // two-entry buffer between capture and storage register
    if (in_valid && in_ready) begin
      if (m_q.buf_cnt == 2'h0 || (m_q.buf_cnt == 2'h1 && out_ready)) begin
        m_d.buf0 = m_q.snap;
      end else begin
        m_d.buf1 = m_q.snap;
      end
    end
    if (out_valid && out_ready) begin
      m_d.store = m_q.buf0;
      if (m_q.buf_cnt == 2'h2) begin
        m_d.buf0 = m_q.buf1;
      end
    end
    m_d.buf_cnt = m_q.buf_cnt + {1'b0, in_valid && in_ready} - {1'b0, out_valid && out_ready};
  end

  // capture shift contents as held before the storage edge
  assign sclk_rise = (m_q.sclk_sync[2] == m_q.sclk_sync[1]) && m_q.sclk_sync[2] && !m_q.sclk_last;
  // clear touches only the snapshot, never storage
  assign clr_now   = (m_q.clr_sync[2] == m_q.clr_sync[1]) && m_q.clr_sync[2];
  assign in_valid  = sclk_rise;
  assign in_ready  = (m_q.buf_cnt != 2'h2);
  assign out_valid = (m_q.buf_cnt != 2'h0);
  assign out_ready = 1'b1;

  always_ff @(posedge clk) begin
    if (srst) begin
      m_q       <= '0;
      m_q.store <= STORE_RST;
      m_q.oe_n  <= 1'b1;
      m_q.oe_sync <= '1;
    end else begin
      m_q <= m_d;
    end
  end

  assign parallel_out  = m_q.store;
  assign parallel_oe_n = {STAGE_W{m_q.oe_n}};
  assign cascade_serial_out = sh_q.stages[STAGE_W-1];

endmodule

// ### hdl/sipo_pkg.sv
// package: widths and reset values for the serial-in parallel-out latch
package sipo_pkg;
  localparam int          STAGE_W    = 8;
  localparam logic [7:0]  SHIFT_RST  = 8'h00;
  localparam logic [7:0]  STORE_RST  = 8'h00;
  localparam int          SYNC_DEPTH = 3;
endpackage

// ### verif/sipo_asserts.sv
// port checker for the serial-in parallel-out latch
`timescale 1ns/100ps
module sipo_asserts
  import sipo_pkg::*;
(
  input wire logic clk, srst, shift_clock, serial_in, shift_clear_n,
  input wire logic storage_clock, output_enable_n, cascade_serial_out,
  input wire logic [STAGE_W-1:0] parallel_out, parallel_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_oe; $stable(output_enable_n)[*8] |-> parallel_oe_n == {8{output_enable_n}}; endproperty
  a_oe: assert property (p_oe) else $error("enable mismatch");
  property p_hold; (!storage_clock)[*8] |=> $stable(parallel_out); endproperty
  a_hold: assert property (p_hold) else $error("outputs moved");
  property p_clr; (!shift_clear_n)[*2] |-> !cascade_serial_out; endproperty
  a_clr: assert property (p_clr) else $error("clear ignored");
  property p_oe_on; (!output_enable_n)[*8] |-> parallel_oe_n == 8'h00; endproperty
  a_oe_on: assert property (p_oe_on) else $error("outputs not driven");
  property p_oe_off; (output_enable_n)[*8] |-> parallel_oe_n == 8'hFF; endproperty
  a_oe_off: assert property (p_oe_off) else $error("outputs not floating");
  property p_oe_same; parallel_oe_n == 8'h00 || parallel_oe_n == 8'hFF; endproperty
  a_oe_same: assert property (p_oe_same) else $error("enable bits differ");
  c_load: cover property ($rose(storage_clock));
  c_clear: cover property ($fell(shift_clear_n));
  c_drive: cover property ($fell(output_enable_n));
endmodule
bind serial_in_parallel_out_latch sipo_asserts sipo_asserts_i (.*);

// ### verif/sipo_host.sv
// host model driving serial frames on the link clock
`timescale 1ns/100ps
module sipo_host (
  output logic shift_clock,
  output logic serial_in
);
  initial begin
    shift_clock = 1'b0;
    serial_in = 1'b0;
  end
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      serial_in = b[i];
      #16 shift_clock = 1'b1;
      #16 shift_clock = 1'b0;
    end
    serial_in = ~serial_in;
  endtask
endmodule

// ### verif/test_serial_in_parallel_out_latch.sv
// bench for the serial-in parallel-out latch
`timescale 1ns/100ps
module test_serial_in_parallel_out_latch;
  import sipo_pkg::*;
  logic clk = 1'b0, srst = 1'b1, clr_n = 1'b1, st = 1'b0, oe_n = 1'b1;
  logic shift_clock, serial_in, cascade_serial_out;
  logic [STAGE_W-1:0] parallel_out, parallel_oe_n;
  int miscompares = 0, total_checks = 0;
  always #50 clk = ~clk;
  sipo_host sipo_host_i (.shift_clock(shift_clock), .serial_in(serial_in));
  serial_in_parallel_out_latch serial_in_parallel_out_latch_i (.clk(clk), .srst(srst),
    .shift_clock(shift_clock), .serial_in(serial_in), .shift_clear_n(clr_n),
    .storage_clock(st), .output_enable_n(oe_n), .parallel_out(parallel_out),
    .parallel_oe_n(parallel_oe_n), .cascade_serial_out(cascade_serial_out));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task automatic store();
    cyc(4);
    st = 1'b1;
    cyc(2);
    st = 1'b0;
    cyc(10);
  endtask
  task automatic t_load();
    oe_n = 1'b0;
    sipo_host_i.send(8'h3C);
    sipo_host_i.send(8'hC3);
    chk("cascade", {7'h00, cascade_serial_out}, 8'h01);
    store();
    chk("par", parallel_out, 8'hC3);
    chk("oe_n", parallel_oe_n, 8'h00);
    $display("done t_load");
  endtask
  task automatic t_clear();
    clr_n = 1'b0;
    cyc(2);
    chk("cascade", {7'h00, cascade_serial_out}, 8'h00);
    chk("par", parallel_out, 8'hC3);
    clr_n = 1'b1;
    store();
    chk("par", parallel_out, 8'h00);
    oe_n = 1'b1;
    cyc(8);
    chk("oe_n", parallel_oe_n, 8'hFF);
    $display("done t_clear");
  endtask
  task automatic stop_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    cyc(20);
    srst = 1'b0;
    cyc(4);
    t_load();
    t_clear();
    stop_test();
  end
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end
endmodule
